// >>> verilog/bus_port_regs.svh
// constants of the host bus port: widths, queue shape and reset values
// assumes inclusion by bare name from every file that needs them
`ifndef BUS_PORT_REGS_SVH
`define BUS_PORT_REGS_SVH

// decode address width, up to twenty host address lines
`define ADDR_W 20
// width of one host data byte
`define DATA_W 8
// write queue word: address above data
`define WQ_W 28
// write queue depth in words
`define WQ_DEPTH 32
// reset value of the address latch
`define ADDR_RST 20'h00000
// reset value of data registers
`define DATA_RST 8'h00

`endif

// >>> verilog/bus_port_pkg.sv
// types of the host bus port: host bus kinds, strobe options, cycle states
// assumes nothing of its surroundings
package bus_port_pkg;

	// how the host presents address and data on the three ports
	typedef enum logic [1:0] {
		BUS_MUX,
		BUS_NONMUX,
		BUS_PAGE,
		BUS_BURST
	} bus_mode_t;

	// meaning of the write control pin
	typedef enum logic {
		WR_STROBE,
		WR_DIRECTION
	} write_mode_t;

	// meaning of the read control pin
	typedef enum logic [1:0] {
		RD_STROBE,
		RD_PHASE_CLK,
		RD_DATA_STROBE,
		RD_FETCH
	} read_mode_t;

	// host bus cycle tracker
	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_READ,
		CYC_WRITE
	} cycle_state_t;

endpackage

// >>> verilog/stream_if.sv
// valid/ready word stream between the port logic and its write queue
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface stream_if #(parameter int W = 28);
	logic         valid;  // word offered
	logic         ready;  // word can be taken
	logic [W-1:0] data;   // the word

	// side that offers words
	modport src (output valid, output data, input ready);
	// side that takes words
	modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/word_fifo.sv
// word queue with registered read data, width and depth as parameters
// assumes one clock, asynchronous active-high reset, depth a power of two
`timescale 1ns/1ns
module word_fifo #(
	parameter int W     = 28,
	parameter int DEPTH = 32
) (
	input  wire logic clk,
	input  wire logic rst,
	stream_if.snk     fill,
	stream_if.src     drain
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];    // storage array
	logic [AW-1:0] wr_ptr_r;       // next write slot
	logic [AW-1:0] rd_ptr_r;       // next read slot
	logic [AW:0]   cnt_r;          // words held in the array
	logic [W-1:0]  dout_r;         // output stage data
	logic          dout_valid_r;   // output stage full
	wire           mem_empty;      // array holds nothing
	wire           push;           // word taken in
	wire           load;           // word moved to output stage

	assign mem_empty   = (cnt_r == '0);
	assign fill.ready  = (cnt_r != (AW+1)'(DEPTH));
	assign push        = fill.valid && fill.ready;
	assign load        = !mem_empty && (!dout_valid_r || drain.ready);
	assign drain.valid = dout_valid_r;
	assign drain.data  = dout_r;

	// storage write, no reset on the array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= fill.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (load)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// registered output stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout_r       <= '0;
			dout_valid_r <= 1'b0;
		end else if (load) begin
			dout_r       <= mem[rd_ptr_r];
			dout_valid_r <= 1'b1;
		end else if (drain.ready) begin
			dout_valid_r <= 1'b0;
		end
	end
endmodule // word_fifo

// >>> verilog/mcu_bus_port_control.sv
// host bus front end: address latch, port mapping, strobe decode, read drive
// assumes host pins synchronous to clk; memories and decode logic outside
//
// Contract
// - multiplexed host: low port carries address and data
// - separate buses: low port takes low address only
// - burst host: low port carries A4/D0 to A11/D7
// - mux or non-mux host: high port takes A8-A15
// - page host: high port carries address and data
// - burst host: high port takes A12-A19
// - address latched by latch or address strobe
// - drive read data only on read and select
// - latched address forwarded to decode logic
// - write pin: write strobe or read/write direction
// - write and read pins feed the logic terms
// - read pin: read strobe, phase clock, data strobe
// - read pin also accepts fetch strobe as read
// - fetch pin: code fetch strobe or generic input
// - active-low reset clears ports and port state; the write queue keeps its words, cleared by rst only
// - reset aborts running flash program or erase
// - strobe rising edge latches address when chosen
// - chip select high disables internal memories
`timescale 1ns/1ns
`include "bus_port_regs.svh"
module mcu_bus_port_control (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    dev_reset_n,
	input  wire logic                    chip_sel_n,
	input  wire bus_port_pkg::bus_mode_t   bus_mode,
	input  wire bus_port_pkg::write_mode_t write_mode,
	input  wire bus_port_pkg::read_mode_t  read_mode,
	input  wire logic                    fetch_on_ctrl2,
	input  wire logic                    as_rising,
	input  wire logic [7:0]              low_addr_data_port_in,
	output logic      [7:0]              low_addr_data_port_out,
	output logic                         low_addr_data_port_oe_n,
	input  wire logic [7:0]              high_addr_data_port_in,
	output logic      [7:0]              high_addr_data_port_out,
	output logic                         high_addr_data_port_oe_n,
	input  wire logic [7:0]              aux_data_in,
	output logic      [7:0]              aux_data_out,
	output logic                         aux_data_oe_n,
	input  wire logic                    write_ctrl_pin,
	input  wire logic                    read_ctrl_pin,
	input  wire logic                    code_fetch_ctrl_pin,
	input  wire logic                    addr_strobe,
	input  wire logic                    block_sel,
	input  wire logic [7:0]              mem_rd_data,
	output logic                         mem_enable,
	output logic      [19:0]             pld_addr,
	output logic                         pld_write_term,
	output logic                         pld_read_term,
	output logic                         pld_fetch_term,
	output logic                         read_cycle,
	output logic                         wq_valid,
	input  wire logic                    wq_ready,
	output logic      [19:0]             wq_addr,
	output logic      [7:0]              wq_data,
	output logic                         wr_wait,
	output logic                         write_lost,
	output logic                         flash_abort
);
	import bus_port_pkg::*;

	// compose the full address from the port bytes for each host kind
	function automatic logic [`ADDR_W-1:0] compose_addr(
		input bus_mode_t  m,
		input logic [7:0] lo,
		input logic [7:0] hi,
		input logic [7:0] aux
	);
		logic [`ADDR_W-1:0] a;
		a = {4'h0, hi, lo};                       // A8-A15 high, A0-A7 low
		if (m == BUS_BURST)
			a = {hi, lo, aux[3:0]};                // A12-A19, A4-A11, A0-A3
		return a;
	endfunction

	// which port carries the data byte for a host kind: 0 low, 1 high, 2 aux
	function automatic logic [1:0] data_port(input bus_mode_t m);
		logic [1:0] p;
		case (m)
			BUS_MUX:    p = 2'h0;
			BUS_BURST:  p = 2'h0;
			BUS_PAGE:   p = 2'h1;
			BUS_NONMUX: p = 2'h2;
			default:    p = 2'h2;
		endcase
		return p;
	endfunction

	// registers
	cycle_state_t       state_r;         // bus cycle tracker
	cycle_state_t       state_nxt;       // its next value
	logic [`ADDR_W-1:0] addr_r;          // address latch
	logic               strobe_prev_r;   // strobe level one cycle back
	logic [`DATA_W-1:0] wdata_r;         // write byte seen during the strobe
	logic [`DATA_W-1:0] rdata_r;         // read byte held on the port
	logic               drive_r;         // read drive active
	logic               pending_r;       // finished write waiting for queue
	logic [`ADDR_W-1:0] pend_addr_r;     // its address
	logic [`DATA_W-1:0] pend_data_r;     // its data
	logic               lost_r;          // write dropped, one-cycle pulse
	logic               abort_r;         // flash abort level
	logic               wterm_r;         // write pin copy for logic terms
	logic               rterm_r;         // read pin copy for logic terms
	logic               fterm_r;         // fetch pin copy for logic terms

	// decode wires
	wire                port_rst;        // device reset pin asserted
	wire [1:0]          dport;           // data carrying port
	wire [`ADDR_W-1:0]  live_addr;       // address on the pins now
	wire                latch_now;       // strobe says take the address
	wire                phase;           // data phase of the host cycle
	wire                dir_read;        // direction pin says read
	wire                rd_strobe;       // read asked on the read pin
	wire                fetch_rd;        // code fetch read on the fetch pin
	wire                rd_active;       // any read in progress
	wire                wr_active;       // write in progress
	wire                drive_en;        // conditions to drive read data
	wire [`DATA_W-1:0]  wbyte;           // data byte on its port now
	wire                wr_done;         // write strobe just ended
	wire                q_ready;         // queue takes a word

	stream_if #(.W(`WQ_W)) wq_in ();     // port logic into the queue
	stream_if #(.W(`WQ_W)) wq_out ();    // queue out to memory side

	assign port_rst  = !dev_reset_n;
	assign dport     = data_port(bus_mode);
	assign live_addr = compose_addr(bus_mode, low_addr_data_port_in,
	                                high_addr_data_port_in, aux_data_in);

	// latch follows a high strobe, or only its rising edge when chosen
	assign latch_now = as_rising ? (addr_strobe && !strobe_prev_r)
	                             : addr_strobe;

	// phase: phase clock is active high, other strobes active low
	assign phase     = (read_mode == RD_PHASE_CLK) ? read_ctrl_pin
	                                               : !read_ctrl_pin;
	assign dir_read  = write_ctrl_pin;

	// read pin decode per option; direction mode qualifies by phase
	assign rd_strobe = (write_mode == WR_DIRECTION) ? (phase && dir_read)
	                 : (read_mode == RD_PHASE_CLK)  ? read_ctrl_pin
	                 : !read_ctrl_pin;
	assign fetch_rd  = fetch_on_ctrl2 && !code_fetch_ctrl_pin;
	assign rd_active = rd_strobe || fetch_rd;
	assign wr_active = (write_mode == WR_DIRECTION) ? (phase && !dir_read)
	                                                : !write_ctrl_pin;

	// drive only on a read that hits a selected block of an enabled chip
	assign drive_en  = rd_active && block_sel && !chip_sel_n && !port_rst;

	// write byte from the port that carries data for this host kind
	assign wbyte     = (dport == 2'h0) ? low_addr_data_port_in
	                 : (dport == 2'h1) ? high_addr_data_port_in
	                 : aux_data_in;
	assign wr_done   = (state_r == CYC_WRITE) && !wr_active;
	assign q_ready   = wq_in.ready;

	// cycle tracker next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CYC_IDLE: begin
				if (rd_active)
					state_nxt = CYC_READ;
				else if (wr_active)
					state_nxt = CYC_WRITE;
			end
			CYC_READ: begin
				if (!rd_active)
					state_nxt = CYC_IDLE;
			end
			CYC_WRITE: begin
				if (!wr_active)
					state_nxt = CYC_IDLE;
			end
			default: state_nxt = CYC_IDLE;
		endcase
	end

	// cycle tracker and address latch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r       <= CYC_IDLE;
			addr_r        <= `ADDR_RST;
			strobe_prev_r <= 1'b0;
		end else if (port_rst) begin
			state_r       <= CYC_IDLE;
			addr_r        <= `ADDR_RST;
			strobe_prev_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			strobe_prev_r <= addr_strobe;
			if (latch_now)
				addr_r <= live_addr;
		end
	end

	// read data stage and drive enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_r <= `DATA_RST;
			drive_r <= 1'b0;
		end else begin
			drive_r <= drive_en;
			if (drive_en)
				rdata_r <= mem_rd_data;
		end
	end

	// write byte capture while the write strobe is active
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wdata_r <= `DATA_RST;
		else if (wr_active)
			wdata_r <= wbyte;
	end

	// finished write waits here until the queue takes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending_r   <= 1'b0;
			pend_addr_r <= `ADDR_RST;
			pend_data_r <= `DATA_RST;
			lost_r      <= 1'b0;
		end else begin
			lost_r <= 1'b0;
			if (port_rst) begin
				pending_r <= 1'b0;
			end else if (wr_done && !chip_sel_n) begin
				// a write ending while an older one still waits is dropped
				if (pending_r && !q_ready) begin
					lost_r <= 1'b1;
				end else begin
					pending_r   <= 1'b1;
					pend_addr_r <= addr_r;
					pend_data_r <= wdata_r;
				end
			end else if (q_ready) begin
				pending_r <= 1'b0;
			end
		end
	end

	// pin copies for the logic terms and the flash abort level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wterm_r <= 1'b1;
			rterm_r <= 1'b1;
			fterm_r <= 1'b1;
			abort_r <= 1'b0;
		end else begin
			wterm_r <= write_ctrl_pin;
			rterm_r <= read_ctrl_pin;
			fterm_r <= code_fetch_ctrl_pin;
			abort_r <= port_rst;
		end
	end

	// write queue between the host port and the memory side
	word_fifo #(
		.W     (`WQ_W),
		.DEPTH (`WQ_DEPTH)
	) u_wq (
		.clk   (clk),
		.rst   (rst),
		.fill  (wq_in),
		.drain (wq_out)
	);

	assign wq_in.valid  = pending_r;
	assign wq_in.data   = {pend_addr_r, pend_data_r};
	assign wq_out.ready = wq_ready;
	assign wq_valid     = wq_out.valid;
	assign wq_addr      = wq_out.data[`WQ_W-1:`DATA_W];
	assign wq_data      = wq_out.data[`DATA_W-1:0];
	assign wr_wait      = !q_ready;

	// port drivers: only the data port of this host kind, only while reading
	assign low_addr_data_port_out   = rdata_r;
	assign high_addr_data_port_out  = rdata_r;
	assign aux_data_out             = rdata_r;
	assign low_addr_data_port_oe_n  = !(drive_r && dport == 2'h0);
	assign high_addr_data_port_oe_n = !(drive_r && dport == 2'h1);
	assign aux_data_oe_n            = !(drive_r && dport == 2'h2);

	// outputs to decode logic and memories
	assign pld_addr       = addr_r;
	assign pld_write_term = wterm_r;
	assign pld_read_term  = rterm_r;
	assign pld_fetch_term = fterm_r;
	assign mem_enable     = !chip_sel_n;
	assign read_cycle     = (state_r == CYC_READ);
	assign write_lost     = lost_r;
	assign flash_abort    = abort_r;
endmodule // mcu_bus_port_control

// >>> verification/bus_port_assertions.sv
// checker of the host bus port, watching the top module's ports only
// assumes a bind onto mcu_bus_port_control and one clock domain
`timescale 1ns/1ns
module bus_port_checker (
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    dev_reset_n,
	input wire logic                    chip_sel_n,
	input wire bus_port_pkg::bus_mode_t bus_mode,
	input wire logic                    as_rising,
	input wire logic [7:0]              low_addr_data_port_in,
	input wire logic [7:0]              high_addr_data_port_in,
	input wire logic [7:0]              aux_data_in,
	input wire logic [7:0]              low_addr_data_port_out,
	input wire logic                    low_addr_data_port_oe_n,
	input wire logic                    high_addr_data_port_oe_n,
	input wire logic                    aux_data_oe_n,
	input wire logic                    write_ctrl_pin,
	input wire logic                    read_ctrl_pin,
	input wire logic                    code_fetch_ctrl_pin,
	input wire logic                    addr_strobe,
	input wire logic                    block_sel,
	input wire logic [7:0]              mem_rd_data,
	input wire logic                    mem_enable,
	input wire logic [19:0]             pld_addr,
	input wire logic                    pld_write_term,
	input wire logic                    pld_read_term,
	input wire logic                    pld_fetch_term,
	input wire logic                    write_lost,
	input wire logic                    flash_abort
);
	import bus_port_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// address the latch should take from the pins, by bus kind
	wire logic [19:0] lat_w = (bus_mode == BUS_BURST) ?
		{high_addr_data_port_in, low_addr_data_port_in, aux_data_in[3:0]} :
		{4'h0, high_addr_data_port_in, low_addr_data_port_in};
	mem_enable_a: assert property (mem_enable == !chip_sel_n)
		else $error("memory enable does not follow chip select");
	drive_cause_a: assert property ($fell(low_addr_data_port_oe_n)
		|-> $past(block_sel) && !$past(chip_sel_n)) else $error("drive without select");
	unsel_off_a: assert property (chip_sel_n || !block_sel || !dev_reset_n
		|=> low_addr_data_port_oe_n && high_addr_data_port_oe_n && aux_data_oe_n)
		else $error("port driven while not selected");
	addr_latch_a: assert property (addr_strobe && !as_rising && dev_reset_n
		|=> pld_addr == $past(lat_w)) else $error("latched address wrong");
	rise_latch_a: assert property (as_rising && addr_strobe && $past(addr_strobe)
		&& dev_reset_n |=> $stable(pld_addr)) else $error("latch taken without rising edge");
	abort_a: assert property (1'b1 |=> flash_abort == !$past(dev_reset_n))
		else $error("flash abort does not follow reset pin");
	terms_a: assert property (dev_reset_n |=> pld_write_term == $past(write_ctrl_pin)
		&& pld_read_term == $past(read_ctrl_pin) && pld_fetch_term == $past(code_fetch_ctrl_pin))
		else $error("logic terms do not follow control pins");
	read_data_a: assert property ($fell(low_addr_data_port_oe_n)
		|-> low_addr_data_port_out == $past(mem_rd_data)) else $error("read byte wrong");
	low_mode_a: assert property (!low_addr_data_port_oe_n
		|-> bus_mode inside {BUS_MUX, BUS_BURST}) else $error("low port data in wrong mode");
	high_mode_a: assert property (!high_addr_data_port_oe_n |-> bus_mode == BUS_PAGE)
		else $error("high port data in wrong mode");
	// main scenarios reached
	read_low_c: cover property ($fell(low_addr_data_port_oe_n));
	read_high_c: cover property ($fell(high_addr_data_port_oe_n));
	lost_c: cover property (write_lost);
endmodule // bus_port_checker

// >>> verification/host_mcu_model.sv
// model of the microcontroller driving the host bus pins
// assumes the bench resolves the shared pins and flags the device's drive
`timescale 1ns/1ns
module host_mcu_model (
	input wire logic                      clk,
	input wire bus_port_pkg::bus_mode_t   bus_mode,
	input wire bus_port_pkg::write_mode_t write_mode,
	input wire bus_port_pkg::read_mode_t  read_mode,
	input wire logic                      fetch_on_ctrl2,
	input wire logic                      as_rising,
	input wire logic                      drive_seen,
	output logic                          addr_strobe,
	output logic                          write_ctrl_pin,
	output logic                          read_ctrl_pin,
	output logic                          code_fetch_ctrl_pin,
	output logic [7:0]                    h_lo,
	output logic [7:0]                    h_hi,
	output logic [7:0]                    h_aux
);
	import bus_port_pkg::*;
	logic on_r = 1'b0; // strobe phase active
	logic wr_r = 1'b0; // current cycle is a write
	wire logic rd_act = on_r && (write_mode == WR_DIRECTION || (!wr_r && !fetch_on_ctrl2));
	// control pins follow the chosen modes at once
	assign write_ctrl_pin = !(on_r && wr_r);
	assign read_ctrl_pin = (read_mode == RD_PHASE_CLK) ? rd_act : !rd_act;
	assign code_fetch_ctrl_pin = !(on_r && !wr_r && fetch_on_ctrl2);
	initial begin
		addr_strobe = 1'b0;
		{h_hi, h_lo, h_aux} = 24'h0;
	end
	// released lines show the inverse of their last level
	task automatic release_pins();
		{h_hi, h_lo, h_aux} = ~{h_hi, h_lo, h_aux};
	endtask
	// one bus cycle: address phase, then a read or write strobe
	task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] d,
		output logic got);
		got = 1'b0;
		@(negedge clk);
		addr_strobe = 1'b1;
		if (bus_mode == BUS_BURST) {h_hi, h_lo, h_aux[3:0]} = a;
		else {h_hi, h_lo} = a[15:0];
		if (as_rising) begin
			@(negedge clk);
			release_pins(); // a level latch would take this
		end
		@(negedge clk);
		addr_strobe = 1'b0;
		release_pins();
		wr_r = wr;
		if (wr && bus_mode == BUS_PAGE) h_hi = d;
		else if (wr && bus_mode == BUS_NONMUX) h_aux = d;
		else if (wr) h_lo = d;
		on_r = 1'b1;
		repeat (2) @(negedge clk);
		for (int n = 0; n < 6 && !wr && !drive_seen; n++) @(negedge clk);
		got = drive_seen;
		@(negedge clk);
		on_r = 1'b0;
		@(negedge clk);
		release_pins();
		repeat (2) @(negedge clk);
	endtask
endmodule // host_mcu_model

// >>> verification/tb_mcu_bus_port_control.sv
// self-checking bench of the host bus port with a microcontroller model
// assumes the design package, header and queue module are compiled first
`timescale 1ns/1ns
module tb_mcu_bus_port_control;
	import bus_port_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, dev_reset_n = 1'b0, chip_sel_n = 1'b0;
	bus_mode_t   bus_mode = BUS_MUX;
	write_mode_t write_mode = WR_STROBE;
	read_mode_t  read_mode = RD_STROBE;
	logic        fetch_on_ctrl2 = 1'b0, as_rising = 1'b0, block_sel = 1'b1, wq_ready = 1'b1;
	logic [7:0]  mem_rd_data = 8'h00, h_lo, h_hi, h_aux;
	logic [7:0]  low_addr_data_port_out, high_addr_data_port_out, aux_data_out;
	logic        low_addr_data_port_oe_n, high_addr_data_port_oe_n, aux_data_oe_n;
	logic        addr_strobe, write_ctrl_pin, read_ctrl_pin, code_fetch_ctrl_pin;
	logic        wq_valid, wr_wait, write_lost, flash_abort, prev_oe_n = 1'b1, lost_seen = 1'b0;
	logic [19:0] wq_addr, pld_addr;
	logic [7:0]  wq_data;
	logic        read_cycle;         // cycle tracker shows a read
	logic [31:0] seed = 32'h062498DC; // xorshift state
	logic [27:0] exp_wr[$];           // queue words expected
	logic [7:0]  exp_rd[$];           // read bytes expected
	int          miscompares = 0, checks_done = 0;
	// shared pins: device level while it drives, else the host's
	wire logic [7:0] low_addr_data_port_in = low_addr_data_port_oe_n ? h_lo : low_addr_data_port_out;
	wire logic [7:0] high_addr_data_port_in = high_addr_data_port_oe_n ? h_hi : high_addr_data_port_out;
	wire logic [7:0] aux_data_in = aux_data_oe_n ? h_aux : aux_data_out;
	// data port of the current bus kind
	wire logic sel_oe_n = (bus_mode == BUS_PAGE) ? high_addr_data_port_oe_n :
		(bus_mode == BUS_NONMUX) ? aux_data_oe_n : low_addr_data_port_oe_n;
	wire logic [7:0] sel_in = (bus_mode == BUS_PAGE) ? high_addr_data_port_in :
		(bus_mode == BUS_NONMUX) ? aux_data_in : low_addr_data_port_in;
	always #50 clk = ~clk;
	mcu_bus_port_control u_dut (.clk, .rst, .dev_reset_n, .chip_sel_n, .bus_mode, .write_mode,
		.read_mode, .fetch_on_ctrl2, .as_rising, .low_addr_data_port_in, .low_addr_data_port_out,
		.low_addr_data_port_oe_n, .high_addr_data_port_in, .high_addr_data_port_out,
		.high_addr_data_port_oe_n, .aux_data_in, .aux_data_out, .aux_data_oe_n, .write_ctrl_pin,
		.read_ctrl_pin, .code_fetch_ctrl_pin, .addr_strobe, .block_sel, .mem_rd_data,
		.mem_enable(), .pld_addr, .pld_write_term(), .pld_read_term(), .pld_fetch_term(),
		.read_cycle, .wq_valid, .wq_ready, .wq_addr, .wq_data, .wr_wait, .write_lost,
		.flash_abort);
	host_mcu_model h (.clk, .bus_mode, .write_mode, .read_mode, .fetch_on_ctrl2, .as_rising,
		.drive_seen(!sel_oe_n), .addr_strobe, .write_ctrl_pin, .read_ctrl_pin,
		.code_fetch_ctrl_pin, .h_lo, .h_hi, .h_aux);
	// next random word
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// compare and count
	task automatic check(input logic [27:0] seen, input logic [27:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one host cycle, its outcome noted before it starts
	task automatic bus_op(input logic wr, input logic ok);
		logic [31:0] r;
		logic [19:0] a;
		logic        got;
		r = rnd();
		a = (bus_mode == BUS_BURST) ? r[19:0] : {4'h0, r[15:0]};
		mem_rd_data = r[27:20];
		if (ok && wr) exp_wr.push_back({a, r[27:20]});
		if (ok && !wr) exp_rd.push_back(r[27:20]);
		h.access(wr, a, r[27:20], got);
		if (!wr) check(got, ok, "read drive");
	endtask
	// newly driven read bytes against the oldest note
	always @(negedge clk) begin
		if (sel_oe_n !== 1'b1 && prev_oe_n === 1'b1) begin
			check(sel_in, (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hXX, "read");
			check(read_cycle, 1'b1, "read cycle");
		end
		prev_oe_n = sel_oe_n;
	end
	// accepted queue words against the oldest note
	always @(posedge clk) begin
		if (wq_valid === 1'b1 && wq_ready)
			check({wq_addr, wq_data}, (exp_wr.size() > 0) ? exp_wr.pop_front() : 28'hX, "wq");
		if (write_lost === 1'b1) lost_seen <= 1'b1;
	end
	// hang guard
	initial begin
		#(30000 * 100);
		miscompares++;
		final_report();
	end
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		// device reset pin stays asserted through power-up, released one cycle later
		@(negedge clk);
		dev_reset_n = 1'b1;
		// every bus kind, writes and reads
		for (int m = 0; m < 4; m++) begin
			bus_mode = bus_mode_t'(m);
			repeat (3) begin
				bus_op(1'b1, 1'b1);
				bus_op(1'b0, 1'b1);
			end
		end
		bus_mode = BUS_MUX;
		// every control pin option, then the rising-edge latch
		for (int k = 0; k < 5; k++) begin
			write_mode = (k < 2) ? WR_DIRECTION : WR_STROBE;
			read_mode = (k == 0) ? RD_PHASE_CLK : (k == 1) ? RD_DATA_STROBE :
				(k == 2) ? RD_FETCH : RD_STROBE;
			fetch_on_ctrl2 = (k == 3);
			as_rising = (k == 4);
			bus_op(1'b1, 1'b1);
			bus_op(1'b0, 1'b1);
		end
		// refusals: deselected chip, then no block selected
		chip_sel_n = 1'b1;
		bus_op(1'b0, 1'b0);
		bus_op(1'b1, 1'b0);
		chip_sel_n = 1'b0;
		block_sel = 1'b0;
		bus_op(1'b0, 1'b0);
		block_sel = 1'b1;
		// fill the queue with the far side stalled
		wq_ready = 1'b0;
		for (int i = 0; i < 35; i++) bus_op(1'b1, i < 34);
		check(wr_wait, 1'b1, "queue full");
		check(lost_seen, 1'b1, "write lost");
		// drain with random stalls
		for (int i = 0; i < 400 && exp_wr.size() > 0; i++) begin
			@(negedge clk);
			wq_ready = 1'(rnd());
		end
		wq_ready = 1'b1;
		repeat (4) @(negedge clk);
		check(28'(exp_wr.size()), 28'h0, "queue drained");
		check(wr_wait, 1'b0, "queue not full");
		// device reset pin in mid-run
		bus_op(1'b1, 1'b1);
		dev_reset_n = 1'b0;
		repeat (3) @(negedge clk);
		check(flash_abort, 1'b1, "abort");
		check(pld_addr, 20'h00000, "latch cleared");
		dev_reset_n = 1'b1;
		repeat (3) @(negedge clk);
		check(28'(exp_rd.size()), 28'h0, "reads done");
		final_report();
	end
endmodule // tb_mcu_bus_port_control
bind mcu_bus_port_control bus_port_checker u_chk (.clk, .rst, .dev_reset_n, .chip_sel_n,
	.bus_mode, .as_rising, .low_addr_data_port_in, .high_addr_data_port_in, .aux_data_in,
	.low_addr_data_port_out, .low_addr_data_port_oe_n, .high_addr_data_port_oe_n,
	.aux_data_oe_n, .write_ctrl_pin, .read_ctrl_pin, .code_fetch_ctrl_pin, .addr_strobe,
	.block_sel, .mem_rd_data, .mem_enable, .pld_addr, .pld_write_term, .pld_read_term,
	.pld_fetch_term, .write_lost, .flash_abort);
